// File: src/program_step_input_select.sv
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "step_input_defines.svh"

// Function
// - Active mode input selects program mode 0
// - Mode setting: on, off, force0, force1
// - Run/halt level starts or stops; 1 inverts
// - Run settings 2 or 3 ignore input
// - Cancel on rising or falling conducting edge
// - Cancel settings 2 or 3 ignore input
// - Select polarity: on, off, always, never
// - Seven select bits form step 0..127
// - Serial control needs no pins or settings
// - Serial commands need no mode switch
// - Table holds 128 steps 0 to 127
module program_step_input_select #(
  parameter int step_bits = 7
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic mode_select_input,
  input wire logic run_halt_input,
  input wire logic program_cancel_input,
  input wire logic [step_bits-1:0] step_select_in,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic mode0_active,
  output logic program_running,
  output logic program_start,
  output logic program_stop,
  output logic program_cancel,
  output logic [step_bits-1:0] step_index
);

  localparam int nin = step_bits + 3;

  typedef struct packed {
    logic [1:0] mode_pol;
    logic [1:0] run_pol;
    logic [1:0] cancel_set;
    logic [2*step_bits-1:0] sel_pol;
    logic cancel_prev;
    logic run_prev;
    logic cancel_seen;
    step_input_pkg::run_state_t run_st;
    logic [step_bits-1:0] step;
    logic start_p;
    logic stop_p;
    logic cancel_p;
    logic mode0;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [nin-1:0] pins_sync;
  logic mode_lvl;
  logic run_lvl;
  logic run_ok;
  logic cancel_lvl;
  logic cancel_ok;
  logic [step_bits-1:0] sel_lvl;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic cmd_start;
  logic cmd_stop;
  logic cmd_cancel;
  logic [31:0] status_word;

  // Pins come from isolated photocouplers, so they are asynchronous.
  input_sync #(
    .width(nin)
  ) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .pin_in({step_select_in, program_cancel_input, run_halt_input, mode_select_input}),
    .pin_sync(pins_sync)
  );

  // Applies a polarity setting to a conducting level; force codes ignore the pin.
  function automatic logic apply_pol(input logic [1:0] pol, input logic lvl);
    logic r;
    r = 1'b0;
    case (step_input_pkg::pol_t'(pol))
      step_input_pkg::pol_on: r = lvl;
      step_input_pkg::pol_off: r = ~lvl;
      step_input_pkg::pol_force_on: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  always_comb begin
    // Code 2 forces mode 0 and code 3 forces mode 1, same as the generic decode.
    mode_lvl = apply_pol(s_q.mode_pol, pins_sync[0]);
    run_lvl = apply_pol(s_q.run_pol[0] ? 2'h1 : 2'h0, pins_sync[1]);
    run_ok = ~s_q.run_pol[1];
    cancel_lvl = apply_pol(s_q.cancel_set[0] ? 2'h1 : 2'h0, pins_sync[2]);
    cancel_ok = ~s_q.cancel_set[1];
  end

  genvar gi;
  generate
    for (gi = 0; gi < step_bits; gi++) begin : g_sel
      assign sel_lvl[gi] = apply_pol(s_q.sel_pol[2*gi +: 2], pins_sync[3+gi]);
    end
  endgenerate

  assign bus_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign bus_wr = bus_req & wb_we_i;
  assign bus_rd = bus_req & ~wb_we_i;
  // Serial commands act regardless of mode and of the pin settings.
  assign cmd_start = bus_wr && wb_adr_i[7:0] == `REG_CMD && wb_sel_i[0]
                     && wb_dat_i[`CMD_START_BIT];
  assign cmd_stop = bus_wr && wb_adr_i[7:0] == `REG_CMD && wb_sel_i[0]
                    && wb_dat_i[`CMD_STOP_BIT];
  assign cmd_cancel = bus_wr && wb_adr_i[7:0] == `REG_CMD && wb_sel_i[0]
                      && wb_dat_i[`CMD_CANCEL_BIT];

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`STAT_MODE0_BIT] = s_q.mode0;
    status_word[`STAT_RUN_BIT] = (s_q.run_st == step_input_pkg::st_run);
    status_word[`STAT_CANCEL_BIT] = s_q.cancel_seen;
    status_word[`STAT_STEP_LSB +: step_bits] = s_q.step;
  end

  always_comb begin
    s_d = s_q;
    if (clk_en) begin
      s_d.start_p = 1'b0;
      s_d.stop_p = 1'b0;
      s_d.cancel_p = 1'b0;
      s_d.ack = bus_req;
      s_d.mode0 = mode_lvl;
      s_d.run_prev = run_lvl;
      s_d.cancel_prev = cancel_lvl;
      // Pin step is loaded only while the pins are in charge of the table; otherwise it holds its value.
      if (mode_lvl) begin
        s_d.step = sel_lvl;
      end
      // Pin-driven start and stop, only in mode 0.
      if (mode_lvl && run_ok && run_lvl && !s_q.run_prev
          && s_q.run_st != step_input_pkg::st_run) begin
        s_d.start_p = 1'b1;
      end else if (mode_lvl && run_ok && !run_lvl && s_q.run_prev
                   && s_q.run_st == step_input_pkg::st_run) begin
        s_d.stop_p = 1'b1;
      end
      // Edge on the polarised level, so setting 1 catches the falling edge.
      if (mode_lvl && cancel_ok && cancel_lvl && !s_q.cancel_prev) begin
        s_d.cancel_p = 1'b1;
      end
      if (cmd_start) begin
        s_d.start_p = 1'b1;
        if (wb_dat_i[`CMD_USE_STEP_BIT]) begin
          s_d.step = wb_dat_i[`CMD_STEP_LSB +: step_bits];
        end
      end
      if (cmd_stop) begin
        s_d.stop_p = 1'b1;
      end
      if (cmd_cancel) begin
        s_d.cancel_p = 1'b1;
      end
      case (s_q.run_st)
        step_input_pkg::st_idle: begin
          if (s_d.start_p) begin
            s_d.run_st = step_input_pkg::st_run;
          end
        end
        step_input_pkg::st_run: begin
          if (s_d.cancel_p) begin
            s_d.run_st = step_input_pkg::st_idle;
          end else if (s_d.stop_p) begin
            s_d.run_st = step_input_pkg::st_halt;
          end
        end
        step_input_pkg::st_halt: begin
          // A halted program restarts where it stopped, or is cancelled.
          if (s_d.cancel_p) begin
            s_d.run_st = step_input_pkg::st_idle;
          end else if (s_d.start_p) begin
            s_d.run_st = step_input_pkg::st_run;
          end
        end
        default: s_d.run_st = step_input_pkg::st_idle;
      endcase
      // Set wins over a clear in the same cycle.
      if (bus_wr && wb_adr_i[7:0] == `REG_STATUS && wb_sel_i[0]
          && wb_dat_i[`STAT_CANCEL_BIT]) begin
        s_d.cancel_seen = 1'b0;
      end
      if (s_d.cancel_p) begin
        s_d.cancel_seen = 1'b1;
      end
      if (bus_wr && wb_sel_i[0]) begin
        if (wb_adr_i[7:0] == `REG_MODE_POL) begin
          s_d.mode_pol = wb_dat_i[1:0];
        end else if (wb_adr_i[7:0] == `REG_RUN_POL) begin
          s_d.run_pol = wb_dat_i[1:0];
        end else if (wb_adr_i[7:0] == `REG_CANCEL_SET) begin
          s_d.cancel_set = wb_dat_i[1:0];
        end else if (wb_adr_i[7:0] == `REG_SEL_POL) begin
          s_d.sel_pol[7:0] = wb_dat_i[7:0];
        end
      end
      if (bus_wr && wb_sel_i[1] && wb_adr_i[7:0] == `REG_SEL_POL) begin
        s_d.sel_pol[2*step_bits-1:8] = wb_dat_i[2*step_bits-1:8];
      end
      s_d.rdata = 32'h0000_0000;
      if (bus_rd) begin
        if (wb_adr_i[7:0] == `REG_MODE_POL) begin
          s_d.rdata[1:0] = s_q.mode_pol;
        end else if (wb_adr_i[7:0] == `REG_RUN_POL) begin
          s_d.rdata[1:0] = s_q.run_pol;
        end else if (wb_adr_i[7:0] == `REG_CANCEL_SET) begin
          s_d.rdata[1:0] = s_q.cancel_set;
        end else if (wb_adr_i[7:0] == `REG_SEL_POL) begin
          s_d.rdata[2*step_bits-1:0] = s_q.sel_pol;
        end else if (wb_adr_i[7:0] == `REG_STATUS) begin
          s_d.rdata = status_word;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{mode_pol: `RST_MODE_POL, run_pol: `RST_RUN_POL,
               cancel_set: `RST_CANCEL_SET, sel_pol: `RST_SEL_POL,
               run_st: step_input_pkg::st_idle, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdata;
  assign mode0_active = s_q.mode0;
  assign program_running = (s_q.run_st == step_input_pkg::st_run);
  assign program_start = s_q.start_p;
  assign program_stop = s_q.stop_p;
  assign program_cancel = s_q.cancel_p;
  assign step_index = s_q.step;

endmodule
`default_nettype wire

// File: src/step_input_defines.svh
`ifndef STEP_INPUT_DEFINES_SVH
`define STEP_INPUT_DEFINES_SVH

// Register byte offsets.
`define REG_MODE_POL 8'h00
`define REG_RUN_POL 8'h04
`define REG_CANCEL_SET 8'h08
`define REG_SEL_POL 8'h0c
`define REG_STATUS 8'h10
`define REG_CMD 8'h14

// Field positions.
`define STAT_MODE0_BIT 0
`define STAT_RUN_BIT 1
`define STAT_CANCEL_BIT 2
`define STAT_STEP_LSB 8
`define CMD_START_BIT 0
`define CMD_STOP_BIT 1
`define CMD_CANCEL_BIT 2
`define CMD_USE_STEP_BIT 3
`define CMD_STEP_LSB 8

// Reset values.
`define RST_MODE_POL 2'h0
`define RST_RUN_POL 2'h0
`define RST_CANCEL_SET 2'h0
`define RST_SEL_POL 14'h0000

`endif

// File: src/step_input_pkg.sv
package step_input_pkg;

  // Two-bit polarity setting decoded for the mode and step-select inputs; run and cancel use bit 0 to invert and bit 1 to disable.
  typedef enum logic [1:0] {
    pol_on = 2'h0,
    pol_off = 2'h1,
    pol_force_on = 2'h2,
    pol_force_off = 2'h3
  } pol_t;

  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_run = 3'h2,
    st_halt = 3'h4
  } run_state_t;

endpackage

// File: src/input_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser for a bundle of pin levels.
module input_sync #(
  parameter int width = 10
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic [width-1:0] pin_in,
  output logic [width-1:0] pin_sync
);

  typedef struct packed {
    logic [width-1:0] first;
    logic [width-1:0] second;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (clk_en) begin
      s_d.first = pin_in;
      s_d.second = s_q.first;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_sync = s_q.second;

endmodule
`default_nettype wire

// File: dv/host_pins.sv
`timescale 1ns/1ns
`default_nettype none
// Host side of the isolated inputs. Levels change only just after a clock edge.
module host_pins (
  input wire logic sys_clk,
  output logic mode_pin,
  output logic run_pin,
  output logic cancel_pin,
  output logic [6:0] sel_pins
);
  initial begin
    {mode_pin, run_pin, cancel_pin, sel_pins} = 10'h000;
  end
  task automatic drive(input logic [9:0] v);
    @(posedge sys_clk);
    {mode_pin, run_pin, cancel_pin, sel_pins} <= v;
  endtask
endmodule
`default_nettype wire

// File: dv/step_select_props.sv
`timescale 1ns/1ns
`default_nettype none
module step_select_props #(
  parameter int step_bits = 7
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic program_running,
  input wire logic program_start,
  input wire logic program_stop,
  input wire logic program_cancel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not acknowledged");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_start_runs; program_start |-> program_running; endproperty
  a_start_runs: assert property (p_start_runs) else $error("start without running");
  property p_rise_start; $rose(program_running) |-> program_start; endproperty
  a_rise_start: assert property (p_rise_start) else $error("run without start");
  property p_stop_halts; program_stop |-> !program_running; endproperty
  a_stop_halts: assert property (p_stop_halts) else $error("stop left running");
  property p_fall_cause; $fell(program_running) |-> program_stop || program_cancel; endproperty
  a_fall_cause: assert property (p_fall_cause) else $error("run ended silently");
  property p_cancel_once; program_cancel |=> !program_cancel; endproperty
  a_cancel_once: assert property (p_cancel_once) else $error("cancel not a pulse");
endmodule
bind program_step_input_select step_select_props #(.step_bits(step_bits)) props (
  .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .program_running(program_running),
  .program_start(program_start), .program_stop(program_stop), .program_cancel(program_cancel));
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic sys_clk, nrst, we, cyc, stb, ack, mode_pin, run_pin, cancel_pin;
  logic mode0, running, start, stop, cancel;
  logic clk_en;
  logic [3:0] sel, sel_mask;
  logic [6:0] sel_pins, step;
  logic [31:0] adr, wdat, rdat, dat_o;
  int mismatches = 0, checked = 0, cycles = 0;
  int n_start = 0, n_stop = 0, n_cancel = 0, e_start = 0, e_stop = 0, e_cancel = 0;
  host_pins host (.sys_clk(sys_clk), .mode_pin(mode_pin), .run_pin(run_pin),
    .cancel_pin(cancel_pin), .sel_pins(sel_pins));
  program_step_input_select uut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
    .mode_select_input(mode_pin), .run_halt_input(run_pin), .program_cancel_input(cancel_pin),
    .step_select_in(sel_pins), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .mode0_active(mode0), .program_running(running), .program_start(start),
    .program_stop(stop), .program_cancel(cancel), .step_index(step));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Pulses are counted mid-cycle so a pulse that lands during a bus cycle is not lost.
  always @(negedge sys_clk) begin
    n_start += (start === 1'b1);
    n_stop += (stop === 1'b1);
    n_cancel += (cancel === 1'b1);
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    adr <= {24'h000000, a};
    we <= w;
    wdat <= d;
    sel <= sel_mask;
    cyc <= 1'b1;
    stb <= 1'b1;
    // Ack and read data are taken at the rising edge where ack is sampled high.
    do @(posedge sys_clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic pulses(input int s, input int p, input int c);
    repeat (6) @(posedge sys_clk);
    e_start += s;
    e_stop += p;
    e_cancel += c;
    check(n_start, e_start, "start count");
    check(n_stop, e_stop, "stop count");
    check(n_cancel, e_cancel, "cancel count");
  endtask
  task automatic t_regs;
    for (int a = 0; a <= 'h20; a += 4) begin
      if (a != 'h14) begin
        wb(a[7:0], 1'b1, 32'h0);
        wb(a[7:0], 1'b0, 32'h0);
        check(rdat, 32'h0, "reset value");
      end
    end
  endtask
  task automatic t_mode;
    for (int s = 0; s < 4; s++) begin
      wb(8'h00, 1'b1, s);
      for (int p = 0; p < 2; p++) begin
        host.drive({p[0], 9'h000});
        repeat (5) @(negedge sys_clk);
        check(mode0, s == 2 || (s < 2 && p != s), "mode select");
      end
    end
  endtask
  task automatic t_step;
    logic [13:0] pol [5] = '{14'h0000, 14'h1555, 14'h2aaa, 14'h3fff, 14'h0009};
    logic [6:0] pin [5] = '{7'h55, 7'h55, 7'h55, 7'h55, 7'h01};
    logic [6:0] exp [5] = '{7'h55, 7'h2a, 7'h7f, 7'h00, 7'h02};
    // The step only follows the pins in mode 0, so force it first.
    wb(8'h00, 1'b1, 32'h2);
    for (int i = 0; i < 5; i++) begin
      wb(8'h0c, 1'b1, {18'h0, pol[i]});
      host.drive({3'b000, pin[i]});
      repeat (5) @(negedge sys_clk);
      check(step, exp[i], "step index");
      wb(8'h0c, 1'b0, 32'h0);
      check(rdat, {18'h0, pol[i]}, "select polarity");
      wb(8'h10, 1'b0, 32'h0);
      check(rdat, {17'h0, exp[i], 8'h01}, "status");
    end
  endtask
  task automatic t_run;
    wb(8'h04, 1'b1, 32'h0);
    host.drive(10'h100);
    pulses(1, 0, 0);
    host.drive(10'h000);
    pulses(0, 1, 0);
    for (int s = 2; s < 4; s++) begin
      wb(8'h04, 1'b1, s);
      host.drive(10'h100);
      pulses(0, 0, 0);
      host.drive(10'h000);
      pulses(0, 0, 0);
    end
    host.drive(10'h100);
    wb(8'h04, 1'b1, 32'h1);
    host.drive(10'h000);
    pulses(1, 0, 0);
    host.drive(10'h100);
    pulses(0, 1, 0);
  endtask
  task automatic t_cancel;
    wb(8'h04, 1'b1, 32'h2);
    wb(8'h08, 1'b1, 32'h0);
    wb(8'h14, 1'b1, 32'h1);
    host.drive(10'h180);
    pulses(1, 0, 1);
    wb(8'h08, 1'b1, 32'h1);
    wb(8'h14, 1'b1, 32'h1);
    host.drive(10'h100);
    pulses(1, 0, 1);
    wb(8'h14, 1'b1, 32'h1);
    for (int s = 2; s < 4; s++) begin
      wb(8'h08, 1'b1, s);
      host.drive(10'h180);
      host.drive(10'h100);
    end
    wb(8'h14, 1'b1, 32'h2);
    pulses(1, 1, 0);
  endtask
  task automatic t_cmd;
    wb(8'h00, 1'b1, 32'h3);
    wb(8'h14, 1'b1, 32'h1);
    wb(8'h10, 1'b0, 32'h0);
    check(rdat[1:0], 2'h2, "command start");
    wb(8'h14, 1'b1, 32'h2);
    wb(8'h14, 1'b1, 32'h7f09);
    pulses(2, 1, 0);
    check(step, 7'h7f, "loaded step");
    wb(8'h14, 1'b1, 32'h4);
    pulses(0, 0, 1);
    wb(8'h10, 1'b0, 32'h0);
    check(rdat, 32'h7f04, "cancel seen");
    wb(8'h10, 1'b1, 32'h4);
    wb(8'h10, 1'b0, 32'h0);
    check(rdat, 32'h7f00, "cancel cleared");
  endtask
  task automatic t_freeze;
    wb(8'h00, 1'b1, 32'h2);
    repeat (5) @(negedge sys_clk);
    check(step, 7'h03, "step before freeze");
    @(posedge sys_clk);
    clk_en <= 1'b0;
    host.drive({3'b000, 7'h40});
    repeat (6) @(negedge sys_clk);
    check(step, 7'h03, "step frozen");
    @(posedge sys_clk);
    clk_en <= 1'b1;
    repeat (6) @(negedge sys_clk);
    check(step, 7'h43, "step after freeze");
    sel_mask = 4'h1;
    wb(8'h0c, 1'b1, 32'h3fff);
    sel_mask = 4'hf;
    wb(8'h0c, 1'b0, 32'h0);
    check(rdat, 32'h00ff, "byte enable");
  endtask
  initial begin
    nrst = 1'b0;
    {cyc, stb, we} = 3'b000;
    clk_en = 1'b1;
    sel = 4'hf;
    sel_mask = 4'hf;
    adr = 32'h0;
    wdat = 32'h0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs();
    t_mode();
    t_step();
    t_run();
    t_cancel();
    t_cmd();
    t_freeze();
    summarize();
  end
endmodule
`default_nettype wire
